// ===== core/asf_host.sv
// Operation
// - pulse reset after power-up before writing
// - strobes high around reset release
// - strobes high throughout replay pulse
// - replay only below capacity, never cascaded
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module asf_host
	import asf_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// device strobes and controls
	output logic                   write_strobe_n,
	output logic                   read_strobe_n,
	output logic                   clear_in_n,
	output logic                   replay_in_n,
	output logic                   expansion_input_n_o,
	output logic                   expansion_input_n_oe,
	// device data
	output logic [DATA_W-1:0]      write_data_bus,
	input  wire logic [DATA_W-1:0] read_data_bus,
	// device flags
	input  wire logic              empty_flag_n,
	input  wire logic              full_flag_n,
	input  wire logic              half_full_flag_n,
	input  wire logic              expansion_output_n
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		asf_state_t        state;
		logic [7:0]        cnt;
		logic              wr_n;
		logic              rd_n;
		logic              rs_n;
		logic              rt_n;
		logic [DATA_W-1:0] dout;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic              cascade;
		logic              first_dev;
		logic              err;
		logic              reset_done;
		logic [14:0]       wcount;
		logic [31:0]       prdata;
		logic              pslverr;
	} asf_host_t;

	asf_host_t s_r;
	asf_host_t s_nxt;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [DATA_W+3:0] pins_s;
	logic [DATA_W-1:0] rdbus_s;
	logic              ef_s;
	logic              ff_s;
	logic              hf_s;
	logic              xo_s;

	asf_sync #(
		.W    (DATA_W + 4),
		.INIT ({{DATA_W{1'b0}}, 4'hf})
	) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({read_data_bus, empty_flag_n, full_flag_n, half_full_flag_n, expansion_output_n}),
		.q    (pins_s)
	);

	assign rdbus_s = pins_s[DATA_W+3:4];
	assign ef_s    = pins_s[3];
	assign ff_s    = pins_s[2];
	assign hf_s    = pins_s[1];
	assign xo_s    = pins_s[0];

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic asf_sel_t reg_sel(input logic [11:0] a);
		case (a)
			OFS_CMD:    reg_sel = SEL_CMD;
			OFS_WDATA:  reg_sel = SEL_WDATA;
			OFS_CFG:    reg_sel = SEL_CFG;
			OFS_STATUS: reg_sel = SEL_STATUS;
			OFS_RDATA:  reg_sel = SEL_RDATA;
			OFS_WCOUNT: reg_sel = SEL_WCOUNT;
			default:    reg_sel = SEL_NONE;
		endcase
	endfunction : reg_sel

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       wr_acc;
		logic       rd_setup;
		asf_sel_t   sel;
		logic [3:0] cmd;
		logic       done;
		logic [7:0] cnt_inc;

		wr_acc   = psel & penable & pwrite;
		rd_setup = psel & ~penable;
		sel      = reg_sel(paddr);
		cmd      = pwdata[3:0];
		cnt_inc  = s_r.cnt + 8'h01;
		s_nxt    = s_r;
		done     = 1'b0;

		// write-one clears the error flag; sets below override it
		if (wr_acc && sel == SEL_STATUS && pwdata[ST_ERR_BIT]) begin
			s_nxt.err = 1'b0;
		end
		if (wr_acc && sel == SEL_WDATA) begin
			s_nxt.wdata = pwdata[DATA_W-1:0];
		end
		if (wr_acc && sel == SEL_CFG) begin
			s_nxt.cascade   = pwdata[CFG_CASCADE_BIT];
			s_nxt.first_dev = pwdata[CFG_FIRST_BIT];
		end
		if (wr_acc && sel == SEL_CMD && s_r.state != ST_IDLE && cmd != 4'h0) begin
			s_nxt.err = 1'b1;
		end

		case (s_r.state)
			ST_IDLE: begin
				s_nxt.cnt = 8'h00;
				if (wr_acc && sel == SEL_CMD) begin
					if (cmd[CMD_RESET_BIT]) begin
						s_nxt.state = ST_RSLOW;
						s_nxt.rs_n  = 1'b0;
					end else if (cmd[CMD_REPLAY_BIT]) begin
						if (s_r.cascade || !s_r.reset_done || s_r.wcount >= CAPACITY) begin
							s_nxt.err = 1'b1;
						end else begin
							s_nxt.state = ST_RTLOW;
							s_nxt.rt_n  = 1'b0;
						end
					end else if (cmd[CMD_POP_BIT]) begin
						if (!ef_s) begin
							s_nxt.err = 1'b1;
						end else begin
							s_nxt.state = ST_RLOW;
							s_nxt.rd_n  = 1'b0;
						end
					end else if (cmd[CMD_PUSH_BIT]) begin
						if (!ff_s || !s_r.reset_done) begin
							s_nxt.err = 1'b1;
						end else begin
							s_nxt.state = ST_WLOW;
							s_nxt.wr_n  = 1'b0;
							s_nxt.dout  = s_r.wdata;
							if (s_r.wcount != 15'h7fff) begin
								s_nxt.wcount = s_r.wcount + 15'h0001;
							end
						end
					end
				end
			end
			ST_WLOW: begin
				s_nxt.cnt = cnt_inc;
				if (cnt_inc >= WLOW_CYC) begin
					s_nxt.wr_n  = 1'b1;
					s_nxt.state = ST_WHOLD;
					s_nxt.cnt   = 8'h00;
				end
			end
			ST_WHOLD: begin
				s_nxt.cnt = cnt_inc;
				if (cnt_inc >= WHOLD_CYC) begin
					done = 1'b1;
				end
			end
			ST_RLOW: begin
				s_nxt.cnt = cnt_inc;
				if (cnt_inc >= RLOW_CYC) begin
					s_nxt.rdata = rdbus_s;
					s_nxt.rd_n  = 1'b1;
					done        = 1'b1;
				end
			end
			ST_RSLOW: begin
				s_nxt.cnt = cnt_inc;
				if (cnt_inc >= RSLOW_CYC) begin
					s_nxt.rs_n       = 1'b1;
					s_nxt.reset_done = 1'b1;
					s_nxt.wcount     = 15'h0000;
					done             = 1'b1;
				end
			end
			ST_RTLOW: begin
				s_nxt.cnt = cnt_inc;
				if (cnt_inc >= RTLOW_CYC) begin
					s_nxt.rt_n = 1'b1;
					done       = 1'b1;
				end
			end
			ST_SETTLE: begin
				// flags and recovery times settle before the next command
				s_nxt.cnt = cnt_inc;
				if (cnt_inc >= SETTLE_CYC) begin
					s_nxt.state = ST_IDLE;
					s_nxt.cnt   = 8'h00;
				end
			end
			default: begin
				s_nxt.state = ST_IDLE;
				s_nxt.cnt   = 8'h00;
				s_nxt.wr_n  = 1'b1;
				s_nxt.rd_n  = 1'b1;
				s_nxt.rs_n  = 1'b1;
				s_nxt.rt_n  = 1'b1;
			end
		endcase

		if (done) begin
			s_nxt.state = ST_SETTLE;
			s_nxt.cnt   = 8'h00;
		end

		// read data and error are prepared in the setup cycle
		if (rd_setup) begin
			s_nxt.pslverr = (sel == SEL_NONE);
			s_nxt.prdata  = 32'h0000_0000;
			case (sel)
				SEL_WDATA:  s_nxt.prdata[DATA_W-1:0] = s_r.wdata;
				SEL_CFG:    s_nxt.prdata[1:0] = {s_r.first_dev, s_r.cascade};
				SEL_STATUS: s_nxt.prdata[6:0] = {s_r.reset_done, s_r.err, ~xo_s, ~hf_s, ~ff_s, ~ef_s,
					(s_r.state != ST_IDLE)};
				SEL_RDATA:  s_nxt.prdata[DATA_W-1:0] = s_r.rdata;
				SEL_WCOUNT: s_nxt.prdata[14:0] = s_r.wcount;
				default:    s_nxt.prdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			// a device reset pulse starts by itself after power-up
			s_r <= '{
				state:      ST_RSLOW,
				cnt:        8'h00,
				wr_n:       1'b1,
				rd_n:       1'b1,
				rs_n:       1'b0,
				rt_n:       1'b1,
				dout:       9'h000,
				wdata:      9'h000,
				rdata:      9'h000,
				cascade:    1'b0,
				first_dev:  1'b0,
				err:        1'b0,
				reset_done: 1'b0,
				wcount:     15'h0000,
				prdata:     32'h0000_0000,
				pslverr:    1'b0
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pready         = psel & penable;
	assign prdata         = s_r.prdata;
	assign pslverr        = s_r.pslverr;
	assign write_strobe_n = s_r.wr_n;
	assign read_strobe_n  = s_r.rd_n;
	assign clear_in_n     = s_r.rs_n;
	assign write_data_bus = s_r.dout;

	// the shared first-load/replay pin is held low on the first chained device
	assign replay_in_n          = s_r.cascade ? ~s_r.first_dev : s_r.rt_n;
	// grounded when standalone, released to the chain otherwise
	assign expansion_input_n_o  = 1'b0;
	assign expansion_input_n_oe = ~s_r.cascade;

endmodule : asf_host

`default_nettype wire

// ===== core/asf_pkg.sv
package asf_pkg;

	// ----------------------------------------------------------------
	// clock and pin timing (slowest speed grade, so any grade works)
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int T_WPW_NS      = 120;
	localparam int T_DS_NS       = 40;
	localparam int T_DH_NS       = 10;
	localparam int T_RPW_NS      = 120;
	localparam int T_A_NS        = 120;
	localparam int T_RS_NS       = 120;
	localparam int T_RSS_NS      = 120;
	localparam int T_RT_NS       = 120;
	localparam int T_RTS_NS      = 120;
	localparam int T_FLAG_NS     = 140;
	localparam int SYNC_CYC      = 2;

	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns2cyc

	localparam logic [7:0] WLOW_CYC   = 8'(ns2cyc((T_WPW_NS > T_DS_NS) ? T_WPW_NS : T_DS_NS));
	localparam logic [7:0] WHOLD_CYC  = 8'(ns2cyc(T_DH_NS));
	localparam logic [7:0] RLOW_CYC   = 8'(((ns2cyc(T_A_NS) + SYNC_CYC + 1) > ns2cyc(T_RPW_NS)) ?
		(ns2cyc(T_A_NS) + SYNC_CYC + 1) : ns2cyc(T_RPW_NS));
	localparam logic [7:0] RSLOW_CYC  = 8'(ns2cyc((T_RS_NS > T_RSS_NS) ? T_RS_NS : T_RSS_NS));
	localparam logic [7:0] RTLOW_CYC  = 8'(ns2cyc((T_RT_NS > T_RTS_NS) ? T_RT_NS : T_RTS_NS));
	localparam logic [7:0] SETTLE_CYC = 8'(ns2cyc(T_FLAG_NS) + SYNC_CYC);

	// ----------------------------------------------------------------
	// device geometry
	// ----------------------------------------------------------------
	localparam int          DATA_W   = 9;
	localparam logic [14:0] CAPACITY = 15'h0800;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CMD    = 12'h000;
	localparam logic [11:0] OFS_WDATA  = 12'h004;
	localparam logic [11:0] OFS_CFG    = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam logic [11:0] OFS_RDATA  = 12'h010;
	localparam logic [11:0] OFS_WCOUNT = 12'h014;

	localparam int CMD_PUSH_BIT   = 0;
	localparam int CMD_POP_BIT    = 1;
	localparam int CMD_RESET_BIT  = 2;
	localparam int CMD_REPLAY_BIT = 3;
	localparam int CFG_CASCADE_BIT = 0;
	localparam int CFG_FIRST_BIT   = 1;
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_EMPTY_BIT = 1;
	localparam int ST_FULL_BIT  = 2;
	localparam int ST_HALF_BIT  = 3;
	localparam int ST_XO_BIT    = 4;
	localparam int ST_ERR_BIT   = 5;
	localparam int ST_RDONE_BIT = 6;

	typedef enum logic [2:0] {
		SEL_CMD    = 3'b000,
		SEL_WDATA  = 3'b001,
		SEL_CFG    = 3'b010,
		SEL_STATUS = 3'b011,
		SEL_RDATA  = 3'b100,
		SEL_WCOUNT = 3'b101,
		SEL_NONE   = 3'b111
	} asf_sel_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_WLOW   = 3'b001,
		ST_WHOLD  = 3'b010,
		ST_RLOW   = 3'b011,
		ST_RSLOW  = 3'b100,
		ST_RTLOW  = 3'b101,
		ST_SETTLE = 3'b110
	} asf_state_t;

endpackage : asf_pkg

// ===== core/asf_sync.sv
`timescale 1ns/1ps
`default_nettype none

module asf_sync #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} asf_sync_t;

	asf_sync_t s_r;
	asf_sync_t s_nxt;

	always_comb begin
		s_nxt.meta = d;
		s_nxt.q    = s_r.meta;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '{meta: INIT, q: INIT};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;

endmodule : asf_sync

`default_nettype wire

// ===== sim/asf_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// strobe fifo device
// ----------------
module asf_dev_model
	import asf_pkg::*;
#(
	parameter int DEPTH = 8
) (
	// strobes and controls
	input wire logic              write_strobe_n,
	input wire logic              read_strobe_n,
	input wire logic              clear_in_n,
	input wire logic              replay_in_n,
	input wire logic              expansion_input_n,
	// data
	input wire logic [DATA_W-1:0] write_data_bus,
	output logic      [DATA_W-1:0] read_data_bus,
	// flags
	output logic                  empty_flag_n,
	output logic                  full_flag_n,
	output logic                  half_full_flag_n,
	output logic                  expansion_output_n
);
	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] last = '0;
	int               wp = 0;
	int               rp = 0;
	int               cnt = 0;
	logic             wact = 1'b0;
	logic             ract = 1'b0;
	assign empty_flag_n = (cnt != 0);
	assign full_flag_n = (cnt != DEPTH);
	assign half_full_flag_n = (cnt <= DEPTH / 2);
	assign expansion_output_n = expansion_input_n ? 1'b1 : half_full_flag_n;
	// released bus shows the inverse of the last word
	assign read_data_bus = ract ? mem[rp] : ~last;
	always @(negedge write_strobe_n) if (clear_in_n && cnt < DEPTH) begin
		wact = 1'b1;
		cnt++;
	end
	always @(posedge write_strobe_n) if (wact) begin
		mem[wp] = write_data_bus;
		wp = (wp + 1) % DEPTH;
		wact = 1'b0;
	end
	always @(negedge read_strobe_n) if (clear_in_n && cnt != 0) ract = 1'b1;
	always @(posedge read_strobe_n) if (ract) begin
		last = mem[rp];
		rp = (rp + 1) % DEPTH;
		cnt--;
		ract = 1'b0;
	end
	always @(negedge clear_in_n) begin
		wp = 0;
		rp = 0;
		cnt = 0;
		wact = 1'b0;
		ract = 1'b0;
	end
	// a chained device reads this pin as first-load and ignores it here
	// chain pin and replay pin can move in one step; look once both settle
	always @(negedge replay_in_n) begin
		#1;
		if (!replay_in_n && !expansion_input_n) begin
			rp = 0;
			cnt = wp;
		end
	end
endmodule : asf_dev_model
`default_nettype wire

// ===== sim/asf_host_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// host pin checks
// ----------------
module asf_host_props
	import asf_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              srst,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [11:0]       paddr,
	input wire logic              pready,
	input wire logic              pslverr,
	// device pins
	input wire logic              write_strobe_n,
	input wire logic              read_strobe_n,
	input wire logic              clear_in_n,
	input wire logic              replay_in_n,
	input wire logic              expansion_input_n_o,
	input wire logic              expansion_input_n_oe,
	input wire logic [DATA_W-1:0] write_data_bus
);
	logic [7:0] wlow_r;
	logic [7:0] rlow_r;
	logic [7:0] clow_r;
	// low-time counters for the three pulses
	always_ff @(posedge clk) begin
		wlow_r <= (srst || write_strobe_n) ? 8'h00 : wlow_r + 8'h01;
		rlow_r <= (srst || read_strobe_n) ? 8'h00 : rlow_r + 8'h01;
		clow_r <= (srst || clear_in_n) ? 8'h00 : clow_r + 8'h01;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence wr_end_s;
		$rose(write_strobe_n);
	endsequence
	sequence rd_end_s;
		$rose(read_strobe_n);
	endsequence
	wr_width_a: assert property (wr_end_s |-> wlow_r == 8'h18)
		else $error("write strobe width wrong");
	wr_hold_a: assert property (wr_end_s |-> $stable(write_data_bus) ##1 $stable(write_data_bus))
		else $error("write data not held");
	rd_width_a: assert property (rd_end_s |-> rlow_r == 8'h1b)
		else $error("read strobe width wrong");
	clr_quiet_a: assert property (!clear_in_n |-> write_strobe_n && read_strobe_n)
		else $error("strobe low during device reset");
	rpl_quiet_a: assert property (!replay_in_n && expansion_input_n_oe |-> write_strobe_n && read_strobe_n)
		else $error("strobe low during replay");
	clr_width_a: assert property ($rose(clear_in_n) |-> clow_r >= 8'h18)
		else $error("device reset pulse too short");
	rst_start_a: assert property ($fell(srst) |-> !clear_in_n && write_strobe_n && read_strobe_n)
		else $error("no device reset after release");
	xi_ground_a: assert property (expansion_input_n_oe |-> !expansion_input_n_o)
		else $error("expansion input not grounded");
	apb_ready_a: assert property (pready == (psel && penable))
		else $error("pready wrong");
	bad_addr_a: assert property (psel && penable && (paddr > 12'h014 || paddr[1:0] != 2'b00) |-> pslverr)
		else $error("unmapped access not flagged");
endmodule : asf_host_props
bind asf_host asf_host_props u_props (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
	.clear_in_n(clear_in_n), .replay_in_n(replay_in_n), .expansion_input_n_o(expansion_input_n_o),
	.expansion_input_n_oe(expansion_input_n_oe), .write_data_bus(write_data_bus));
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// controller bench
// ----------------
module testbench;
	import asf_pkg::*;
	localparam int          DEPTH = 8;
	localparam logic [31:0] C_PUSH = 32'h1 << CMD_PUSH_BIT;
	localparam logic [31:0] C_POP = 32'h1 << CMD_POP_BIT;
	localparam logic [31:0] C_CLR = 32'h1 << CMD_RESET_BIT;
	localparam logic [31:0] C_RPL = 32'h1 << CMD_REPLAY_BIT;
	typedef struct {logic [31:0] e; logic [31:0] m;} asf_note_t;
	logic clk, srst, psel, penable, pwrite, want, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ws_n, rs_n, clr_n, rt_n, xi_o, xi_oe, xi_n, ef_n, ff_n, hf_n, xo_n;
	logic [DATA_W-1:0] wdb, rdb;
	logic [15:0] lfsr;
	logic [8:0] words[$];
	logic [8:0] keep[3];
	asf_note_t notes[$];
	asf_note_t nt;
	int errors, comparisons, cyc, i;
	asf_host DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_strobe_n(ws_n),
		.read_strobe_n(rs_n), .clear_in_n(clr_n), .replay_in_n(rt_n), .expansion_input_n_o(xi_o),
		.expansion_input_n_oe(xi_oe), .write_data_bus(wdb), .read_data_bus(rdb), .empty_flag_n(ef_n),
		.full_flag_n(ff_n), .half_full_flag_n(hf_n), .expansion_output_n(xo_n));
	// released expansion pin is pulled high on the board
	assign xi_n = xi_oe ? xi_o : 1'b1;
	asf_dev_model #(.DEPTH(DEPTH)) u_dev (.write_strobe_n(ws_n), .read_strobe_n(rs_n), .clear_in_n(clr_n),
		.replay_in_n(rt_n), .expansion_input_n(xi_n), .write_data_bus(wdb), .read_data_bus(rdb),
		.empty_flag_n(ef_n), .full_flag_n(ff_n), .half_full_flag_n(hf_n), .expansion_output_n(xo_n));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [15:0] lfsr_step(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_step
	task automatic results();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c,
		input logic [31:0] e, input logic [31:0] m);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		want <= c;
		if (c) notes.push_back('{e, m});
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		want <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 32'h0, 32'h0);
	endtask : wr
	task automatic chk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, 1'b1, e, m);
	endtask : chk
	task automatic idle();
		do begin
			apb(1'b0, OFS_STATUS, 32'h0, 1'b0, 32'h0, 32'h0);
		end while (rd[ST_BUSY_BIT] !== 1'b0);
	endtask : idle
	task automatic cmd(input logic [31:0] c);
		wr(OFS_CMD, c);
		idle();
	endtask : cmd
	task automatic st(input logic e, input logic f, input logic h, input logic er);
		chk(OFS_STATUS, {25'h0, 1'b1, er, 1'b0, h, f, e, 1'b0}, 32'h6e);
	endtask : st
	task automatic push(input logic [8:0] d);
		wr(OFS_WDATA, {23'h0, d});
		cmd(C_PUSH);
	endtask : push
	task automatic pop(input logic [8:0] e);
		cmd(C_POP);
		chk(OFS_RDATA, {23'h0, e}, 32'hffffffff);
	endtask : pop
	// scoreboard: oldest note against each checked read
	always @(posedge clk) if (psel && penable && pready === 1'b1 && !pwrite && want && notes.size() > 0) begin
		nt = notes.pop_front();
		comparisons++;
		if ((prdata & nt.m) !== (nt.e & nt.m)) begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, prdata & nt.m, nt.e & nt.m);
		end
		comparisons++;
		if (pslverr !== (paddr > OFS_WCOUNT || paddr[1:0] != 2'b00)) begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, pslverr, (paddr > OFS_WCOUNT || paddr[1:0] != 2'b00));
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end
	initial begin
		{psel, penable, pwrite, want, paddr, pwdata} = '0;
		{errors, comparisons, cyc} = '0;
		srst = 1'b1;
		lfsr = 16'h832c;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		idle();
		st(1'b1, 1'b0, 1'b0, 1'b0);
		cmd(C_POP);
		st(1'b1, 1'b0, 1'b0, 1'b1);
		wr(OFS_STATUS, 32'h20);
		for (i = 0; i < DEPTH; i++) begin
			lfsr = lfsr_step(lfsr);
			words.push_back(lfsr[8:0]);
			push(lfsr[8:0]);
			if (i == DEPTH / 2 - 1) st(1'b0, 1'b0, 1'b0, 1'b0);
			if (i == DEPTH / 2) st(1'b0, 1'b0, 1'b1, 1'b0);
		end
		st(1'b0, 1'b1, 1'b1, 1'b0);
		push(9'h155);
		st(1'b0, 1'b1, 1'b1, 1'b1);
		wr(OFS_STATUS, 32'h20);
		pop(words.pop_front());
		st(1'b0, 1'b0, 1'b1, 1'b0);
		while (words.size() > 0) begin
			pop(words.pop_front());
			if (words.size() == DEPTH / 2) st(1'b0, 1'b0, 1'b0, 1'b0);
		end
		st(1'b1, 1'b0, 1'b0, 1'b0);
		cmd(C_CLR);
		chk(OFS_WCOUNT, 32'h0, 32'hffffffff);
		for (i = 0; i < 3; i++) begin
			lfsr = lfsr_step(lfsr);
			keep[i] = lfsr[8:0];
			push(keep[i]);
		end
		pop(keep[0]);
		pop(keep[1]);
		cmd(C_RPL);
		st(1'b0, 1'b0, 1'b0, 1'b0);
		for (i = 0; i < 3; i++) pop(keep[i]);
		st(1'b1, 1'b0, 1'b0, 1'b0);
		chk(12'h018, 32'h0, 32'hffffffff);
		wr(OFS_CFG, 32'h3);
		cmd(C_RPL);
		st(1'b1, 1'b0, 1'b0, 1'b1);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		idle();
		st(1'b1, 1'b0, 1'b0, 1'b0);
		chk(OFS_CFG, 32'h0, 32'h3);
		chk(OFS_WCOUNT, 32'h0, 32'hffffffff);
		results();
	end
endmodule : testbench
`default_nettype wire
